// ==== parallel_load_shift_register8.v ====
`timescale 1ns/1ps
`include "piso_shift_map.vh"

module parallel_load_shift_register8 #(
  parameter STAGES = `STAGE_COUNT,
  parameter FIFO_W = `FIFO_WIDTH,
  parameter FIFO_D = `FIFO_DEPTH,
  parameter PTR_W  = `FIFO_PTR_W
) (
  input  wire              ref_clk,
  input  wire              rstn,
  input  wire              loadShiftSelect,
  input  wire              shiftClock,
  input  wire              clockGateInput,
  input  wire              chainInput,
  input  wire [STAGES-1:0] parallelIn,
  output wire              serialOut,
  output wire              serialOutN,
  output wire              shiftStrobe,
  output wire              loadActive,
  output wire [FIFO_W-1:0] byteData,
  output wire              byteValid,
  input  wire              byteReady,
  output wire [PTR_W:0]    byteLevel,
  output wire              overrun,
  input  wire              overrunClear
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [STAGES-1:0]      stage_ff;
  wire [STAGES-1:0]      nxt_stage;
  reg                    stageN_ff;
  reg                    gateHist_ff;
  wire                   gateOr;
  wire                   shiftEvent;
  wire                   loadEvent;
  reg  [`SHIFT_CNT_W-1:0] shiftCnt_ff;
  reg  [`SHIFT_CNT_W-1:0] nxt_shiftCnt;
  reg  [FIFO_W-1:0]      assemble_ff;
  reg  [FIFO_W-1:0]      nxt_assemble;
  wire                   byteDone;
  reg                    pendValid_ff;
  reg  [FIFO_W-1:0]      pendData_ff;
  wire                   pushReady;
  reg                    overrun_ff;
  wire                   overrunSet;

  // ****************************************************************
  // Next value of one stage
  // ****************************************************************
  // Load beats shift, shift beats hold
  function stage_next;
    input doLoad;
    input doShift;
    input parBit;
    input prevBit;
    input curBit;
    begin
      if (doLoad) begin
        stage_next = parBit;
      end else if (doShift) begin
        stage_next = prevBit;
      end else begin
        stage_next = curBit;
      end
    end
  endfunction

  // ****************************************************************
  // Gated clock edge detection
  // ****************************************************************
  // Clock and gate are interchangeable, so the shift edge is the
  // rise of their OR; a held high level of either means no change
  assign gateOr     = shiftClock | clockGateInput;
  assign loadEvent  = ~loadShiftSelect;
  assign shiftEvent = loadShiftSelect & gateOr & ~gateHist_ff;

  // History of the OR, tracked during load as well so that leaving
  // load with the clock already high does not count as an edge
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gateHist_ff <= `GATE_HIST_RST;
    end else begin
      gateHist_ff <= gateOr;
    end
  end

  // ****************************************************************
  // Storage chain
  // ****************************************************************
  // First stage takes the chain input on a shift
  assign nxt_stage[`FIRST_STAGE] = stage_next(loadEvent, shiftEvent,
    parallelIn[`FIRST_STAGE], chainInput, stage_ff[`FIRST_STAGE]);

  // Every later stage takes its predecessor on a shift
  genvar gi;
  generate
    for (gi = `FIRST_STAGE + 1; gi < STAGES; gi = gi + 1) begin : g_stage
      assign nxt_stage[gi] = stage_next(loadEvent, shiftEvent,
        parallelIn[gi], stage_ff[gi-1], stage_ff[gi]);
    end
  endgenerate

  // Chain registers, parallel load overrides any edge
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage_ff  <= {STAGES{`STAGE_RST}};
      stageN_ff <= `STAGE_N_RST;
    end else begin
      stage_ff  <= nxt_stage;
      stageN_ff <= ~nxt_stage[STAGES-1];
    end
  end

  // ****************************************************************
  // Serial and status outputs
  // ****************************************************************
  // Last stage in true and complementary form
  assign serialOut   = stage_ff[STAGES-1];
  assign serialOutN  = stageN_ff;
  // One-cycle pulse on each accepted shift
  assign shiftStrobe = shiftEvent;
  // High while parallel load is in force
  assign loadActive  = loadEvent;

  // ****************************************************************
  // Byte monitor: gathers the bits that leave the last stage
  // ****************************************************************
  // Bit leaving on a shift is the last stage before the shift,
  // gathered first bit lowest; a load restarts byte framing
  always @* begin
    nxt_shiftCnt = shiftCnt_ff;
    nxt_assemble = assemble_ff;
    if (loadEvent) begin
      nxt_shiftCnt = `SHIFT_CNT_RST;
      nxt_assemble = `BYTE_RST;
    end else if (shiftEvent) begin
      nxt_shiftCnt = shiftCnt_ff + 1'b1;
      nxt_assemble = {stage_ff[STAGES-1], assemble_ff[FIFO_W-1:1]};
    end
  end

  // A byte is complete on the eighth shift after a load
  assign byteDone = shiftEvent & (shiftCnt_ff == `SHIFT_CNT_LAST);

  // Monitor counters
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shiftCnt_ff <= `SHIFT_CNT_RST;
      assemble_ff <= `BYTE_RST;
    end else begin
      shiftCnt_ff <= nxt_shiftCnt;
      assemble_ff <= nxt_assemble;
    end
  end

  // ****************************************************************
  // Hand-off into the buffer
  // ****************************************************************
  // One-word holding stage in front of the FIFO; a full FIFO stalls
  // it, and a further byte arriving while it stalls is dropped
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pendValid_ff <= 1'b0;
      pendData_ff  <= `BYTE_RST;
    end else begin
      if (byteDone && (!pendValid_ff || pushReady)) begin
        pendValid_ff <= 1'b1;
        pendData_ff  <= {stage_ff[STAGES-1], assemble_ff[FIFO_W-1:1]};
      end else if (pushReady) begin
        pendValid_ff <= 1'b0;
      end
    end
  end

  // Lost byte when the holding stage cannot move
  assign overrunSet = byteDone & pendValid_ff & ~pushReady;

  // Sticky loss flag, a set in the clearing cycle wins
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overrun_ff <= 1'b0;
    end else if (overrunSet) begin
      overrun_ff <= 1'b1;
    end else if (overrunClear) begin
      overrun_ff <= 1'b0;
    end
  end

  assign overrun = overrun_ff;

  // ****************************************************************
  // Monitor FIFO
  // ****************************************************************
  byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D),
    .PTR_W (PTR_W)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inData   (pendData_ff),
    .inValid  (pendValid_ff),
    .inReady  (pushReady),
    .outData  (byteData),
    .outValid (byteValid),
    .outReady (byteReady),
    .level    (byteLevel)
  );

endmodule

// ==== piso_shift_map.vh ====
`ifndef PISO_SHIFT_MAP_VH
`define PISO_SHIFT_MAP_VH

// ****************************************************************
// Chain geometry
// ****************************************************************
// Number of storage stages in the chain
`define STAGE_COUNT      8
// Index of the stage fed by the chain input
`define FIRST_STAGE      0
// Index of the stage that drives the serial outputs
`define LAST_STAGE       7
// Width of the shift counter of the byte monitor
`define SHIFT_CNT_W      3

// ****************************************************************
// Reset values
// ****************************************************************
// Stage contents after reset
`define STAGE_RST        1'h0
// Complementary output after reset, inverse of the last stage
`define STAGE_N_RST      1'h1
// Gated clock history after reset, high so a held level is no edge
`define GATE_HIST_RST    1'h1
// Shift counter after reset
`define SHIFT_CNT_RST    3'h0
// Count at which a whole byte has left the chain
`define SHIFT_CNT_LAST   3'h7
// Captured byte after reset
`define BYTE_RST         8'h00

// ****************************************************************
// Monitor buffer
// ****************************************************************
// Word width of the monitor FIFO
`define FIFO_WIDTH       8
// Word depth of the monitor FIFO
`define FIFO_DEPTH       4
// Pointer width for that depth
`define FIFO_PTR_W       2

`endif

// ==== byte_fifo.v ====
`timescale 1ns/1ps
`include "piso_shift_map.vh"

// ****************************************************************
// Synchronous FIFO with valid and ready on both sides
// ****************************************************************
module byte_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter PTR_W = `FIFO_PTR_W
) (
  input  wire             ref_clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady,
  output wire [PTR_W:0]   level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtr_ff;
  reg [PTR_W-1:0] rdPtr_ff;
  reg [PTR_W:0]   count_ff;
  wire            doPush;
  wire            doPop;

  // Honest full and empty flags from the word count
  assign inReady  = (count_ff != DEPTH[PTR_W:0]);
  assign outValid = (count_ff != {(PTR_W+1){1'b0}});
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;
  assign outData  = mem[rdPtr_ff];
  assign level    = count_ff;

  // Storage array, written only on an accepted push
  always @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Pointers and occupancy
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_ff <= {PTR_W{1'b0}};
      rdPtr_ff <= {PTR_W{1'b0}};
      count_ff <= {(PTR_W+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

// ==== shift_chain_properties.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Port checks of the shift chain
// ****************************************************************
module shift_chain_checker #(
  parameter STAGES = 8
) (
  input wire              ref_clk,
  input wire              rstn,
  input wire              loadShiftSelect,
  input wire              shiftClock,
  input wire              clockGateInput,
  input wire [STAGES-1:0] parallelIn,
  input wire              serialOut,
  input wire              serialOutN,
  input wire              shiftStrobe,
  input wire              loadActive
);
  // Either pin can clock the chain
  wire clkOr = shiftClock | clockGateInput;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  out_pair_a: assert property (serialOutN == !serialOut)
    else $error("outputs not complementary");
  load_value_a: assert property (!loadShiftSelect |=>
    serialOut == $past(parallelIn[STAGES-1])) else $error("bad load");
  load_wins_a: assert property (!loadShiftSelect |-> loadActive
    && !shiftStrobe ##1 serialOutN == !$past(parallelIn[STAGES-1]))
    else $error("load not overriding");
  edge_shift_a: assert property ($past(rstn) && loadShiftSelect
    && clkOr && !$past(clkOr) |-> shiftStrobe) else $error("missed shift");
  strobe_cause_a: assert property (shiftStrobe |->
    loadShiftSelect && clkOr ##1 !shiftStrobe) else $error("stray shift");
  hold_still_a: assert property (loadShiftSelect && !shiftStrobe
    |=> $stable(serialOut)) else $error("chain moved");
  first_step_a: assert property (!loadShiftSelect ##1 shiftStrobe
    |=> serialOut == $past(parallelIn[STAGES-2], 2)) else $error("step1");
  two_steps_a: assert property (!loadShiftSelect ##1 shiftStrobe
    ##1 loadShiftSelect ##1 shiftStrobe
    |=> serialOut == $past(parallelIn[STAGES-3], 4))
    else $error("step2");
endmodule

bind parallel_load_shift_register8 shift_chain_checker #(
  .STAGES(STAGES)) shift_chain_checker_inst (.ref_clk, .rstn,
  .loadShiftSelect, .shiftClock, .clockGateInput, .parallelIn,
  .serialOut, .serialOutN, .shiftStrobe, .loadActive);

// ==== shift_controller.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Controlling logic that loads and clocks the chain
// ****************************************************************
module shift_controller (
  input  wire        ref_clk,
  output logic       loadShiftSelect,
  output logic       shiftClock,
  output logic       clockGateInput,
  output logic       chainInput,
  output logic [7:0] parallelIn
);
  // Idle in shift mode with both clocks low
  initial begin
    loadShiftSelect = 1'h1;
    shiftClock = 1'h0;
    clockGateInput = 1'h0;
    chainInput = 1'h0;
    parallelIn = 8'h00;
  end

  // Two load cycles, other pins wiggled in the first
  task automatic load(input logic [7:0] d, input logic [2:0] junk);
    @(negedge ref_clk);
    loadShiftSelect = 1'h0;
    parallelIn = d;
    {shiftClock, clockGateInput, chainInput} = junk;
    @(negedge ref_clk);
    shiftClock = 1'h0;
    clockGateInput = 1'h0;
  endtask

  // Mode 0 clock, 1 gate with clock low, 2 clock then inhibit
  task automatic shift(input logic [1:0] mode, input logic bitIn);
    @(negedge ref_clk);
    loadShiftSelect = 1'h1;
    parallelIn = ~parallelIn;
    chainInput = bitIn;
    if (mode == 2'h1) clockGateInput = 1'h1;
    else shiftClock = 1'h1;
    if (mode == 2'h2) begin
      @(negedge ref_clk);
      clockGateInput = 1'h1;
      @(negedge ref_clk);
      shiftClock = 1'h0;
    end
    @(negedge ref_clk);
    shiftClock = 1'h0;
    clockGateInput = 1'h0;
    chainInput = ~bitIn;
  endtask
endmodule

// ==== test_parallel_load_shift_register8.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Random bytes through chain and monitor buffer
// ****************************************************************
module test_parallel_load_shift_register8;
  logic        ref_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        byteReady = 1'h0;
  logic        overrunClear = 1'h0;
  wire         loadShiftSelect, shiftClock, clockGateInput, chainInput;
  wire         serialOut, serialOutN, byteValid, overrun;
  wire  [7:0]  parallelIn, byteData;
  wire  [2:0]  byteLevel;
  logic [31:0] seed = 32'h00000033;
  logic [7:0]  refReg;
  logic [7:0]  expQ[$];
  int          n_mismatch = 0;
  int          samples_checked = 0;

  // Clock of 50 ns
  always #25 ref_clk = ~ref_clk;

  parallel_load_shift_register8 parallel_load_shift_register8_inst (
    .ref_clk, .rstn, .loadShiftSelect, .shiftClock, .clockGateInput,
    .chainInput, .parallelIn, .serialOut, .serialOutN,
    .shiftStrobe(), .loadActive(), .byteData, .byteValid, .byteReady,
    .byteLevel, .overrun, .overrunClear);
  shift_controller shift_controller_inst (.ref_clk, .loadShiftSelect,
    .shiftClock, .clockGateInput, .chainInput, .parallelIn);

  // Random source and expected-byte helper
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) rev8[i] = d[7-i];
  endfunction

  task automatic check(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Load a byte, shift it out and follow the serial outputs
  task automatic sendByte(input logic [7:0] d);
    logic [31:0] r;
    r = xorshift();
    shift_controller_inst.load(d, r[2:0]);
    refReg = d;
    for (int k = 0; k < 8; k++) begin
      r = xorshift();
      shift_controller_inst.shift(k < 2 ? 2'h0 : 2'(r[1:0] % 3), r[8]);
      refReg = {refReg[6:0], r[8]};
      check("serialOut", {7'h00, refReg[7]}, {7'h00, serialOut});
      check("serialOutN", {7'h00, ~refReg[7]}, {7'h00, serialOutN});
    end
  endtask

  // Main sequence
  initial begin
    logic [7:0] d;
    repeat (16) @(negedge ref_clk);
    check("rstOut", 8'h00, {7'h00, serialOut});
    check("rstLevel", 8'h00, {5'h00, byteLevel});
    rstn = 1'h1;
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h80 : 8'(xorshift() >> 3);
      sendByte(d);
      if (i < 5) expQ.push_back(rev8(d));
    end
    repeat (3) @(negedge ref_clk);
    check("level", 8'h04, {5'h00, byteLevel});
    check("overrun", 8'h01, {7'h00, overrun});
    while (expQ.size() > 0) begin
      check("byteData", expQ.pop_front(), byteData);
      check("byteValid", 8'h01, {7'h00, byteValid});
      byteReady = 1'h1;
      @(negedge ref_clk);
      byteReady = 1'h0;
      @(negedge ref_clk);
    end
    check("empty", 8'h00, {7'h00, byteValid});
    overrunClear = 1'h1;
    @(negedge ref_clk);
    overrunClear = 1'h0;
    check("cleared", 8'h00, {7'h00, overrun});
    rstn = 1'h0;
    @(negedge ref_clk);
    check("midReset", 8'h00, {7'h00, serialOut});
    rstn = 1'h1;
    sendByte(8'h5C);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule
